// ==== src/dac_data_registers.v ====
// Top of the dual-channel converter data registers, an APB slave.
// Assumes APB signals synchronous to clk_in and single-cycle hardware event pulses.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "dac_data_regs.vh"
module dac_data_registers #(
   parameter WIDTH = 12
) (
   input  wire             clk_in,
   input  wire             reset_in,
   input  wire             psel_in,
   input  wire             penable_in,
   input  wire             pwrite_in,
   input  wire [7:0]       paddr_in,
   input  wire [31:0]      pwdata_in,
   input  wire             ch1_hw_trigger_in,
   input  wire             ch2_hw_trigger_in,
   input  wire             ch1_underrun_in,
   input  wire             ch2_underrun_in,
   output reg  [31:0]      prdata_out,
   output reg              pready_out,
   output reg              pslverr_out,
   output reg  [WIDTH-1:0] ch1_output_out,
   output reg  [WIDTH-1:0] ch2_output_out,
   output reg              irq_out
);
   reg  [31:0]      control_reg;
   reg  [31:0]      status_reg;
   reg  [31:0]      mask_reg;
   reg  [31:0]      rdata_next;
   reg              known_next;
   reg              wr1;
   reg              wr2;
   reg  [WIDTH-1:0] data1;
   reg  [WIDTH-1:0] data2;
   wire             setup;
   wire             wr_go;
   wire [WIDTH-1:0] hold1;
   wire [WIDTH-1:0] hold2;
   wire [WIDTH-1:0] out1;
   wire [WIDTH-1:0] out2;
   wire             soft1;
   wire             soft2;
   wire [31:0]      set_bits;
   wire [31:0]      irq_gate;

   // Zero wait states: pready rises one edge after the setup cycle
   assign setup = psel_in & ~penable_in;
   assign wr_go = psel_in & penable_in & pready_out & pwrite_in;

   // Every holding format narrows to one twelve-bit value per channel
   always @* begin
      wr1   = 1'b0;
      wr2   = 1'b0;
      data1 = `RESET_VALUE12;
      data2 = `RESET_VALUE12;
      if (wr_go) begin
         case (paddr_in)
            `OFF_CH1_HOLD_12R: begin
               wr1   = 1'b1;
               data1 = pwdata_in[11:0];
            end
            `OFF_CH1_HOLD_12L: begin
               wr1   = 1'b1;
               data1 = pwdata_in[15:4];
            end
            `OFF_CH1_HOLD_8R: begin
               wr1   = 1'b1;
               data1 = {pwdata_in[7:0], 4'h0};
            end
            `OFF_CH2_HOLD_12R: begin
               wr2   = 1'b1;
               data2 = pwdata_in[11:0];
            end
            `OFF_CH2_HOLD_12L: begin
               wr2   = 1'b1;
               data2 = pwdata_in[15:4];
            end
            `OFF_CH2_HOLD_8R: begin
               wr2   = 1'b1;
               data2 = {pwdata_in[7:0], 4'h0};
            end
            `OFF_BOTH_HOLD_12R: begin
               wr1   = 1'b1;
               wr2   = 1'b1;
               data1 = pwdata_in[11:0];
               data2 = pwdata_in[27:16];
            end
            `OFF_BOTH_HOLD_12L: begin
               wr1   = 1'b1;
               wr2   = 1'b1;
               data1 = pwdata_in[15:4];
               data2 = pwdata_in[31:20];
            end
            `OFF_BOTH_HOLD_8R: begin
               wr1   = 1'b1;
               wr2   = 1'b1;
               data1 = {pwdata_in[7:0], 4'h0};
               data2 = {pwdata_in[15:8], 4'h0};
            end
            default: begin
               wr1 = 1'b0;
            end
         endcase
      end
   end

   wire trig_wr = wr_go & (paddr_in == `OFF_SOFT_TRIGGER);

   dac_channel #(.WIDTH(WIDTH)) channel1 (
      .clk_in           (clk_in),
      .reset_in         (reset_in),
      .hold_write_in    (wr1),
      .hold_data_in     (data1),
      .trig_enable_in   (control_reg[`BIT_CH1_TRIG_ENABLE]),
      .soft_set_in      (trig_wr & pwdata_in[`BIT_CH1_SOFT_TRIGGER]),
      .soft_clear_in    (trig_wr & ~pwdata_in[`BIT_CH1_SOFT_TRIGGER]),
      .hw_trigger_in    (ch1_hw_trigger_in),
      .hold_value_out   (hold1),
      .output_value_out (out1),
      .soft_trigger_out (soft1)
   );

   dac_channel #(.WIDTH(WIDTH)) channel2 (
      .clk_in           (clk_in),
      .reset_in         (reset_in),
      .hold_write_in    (wr2),
      .hold_data_in     (data2),
      .trig_enable_in   (control_reg[`BIT_CH2_TRIG_ENABLE]),
      .soft_set_in      (trig_wr & pwdata_in[`BIT_CH2_SOFT_TRIGGER]),
      .soft_clear_in    (trig_wr & ~pwdata_in[`BIT_CH2_SOFT_TRIGGER]),
      .hw_trigger_in    (ch2_hw_trigger_in),
      .hold_value_out   (hold2),
      .output_value_out (out2),
      .soft_trigger_out (soft2)
   );

   assign set_bits = {2'b00, ch2_underrun_in, 15'h0000, ch1_underrun_in, 13'h0000};
   // Channel 2 needs both its control enable and the mask bit
   assign irq_gate = mask_reg & {2'b00, control_reg[`BIT_CH2_UNDERRUN_IEN], 15'h7FFF,
                                 1'b1, 13'h0000};

   always @* begin
      rdata_next = `RESET_WORD;
      known_next = 1'b1;
      case (paddr_in)
         `OFF_CONTROL:         rdata_next = control_reg;
         `OFF_SOFT_TRIGGER:    rdata_next = `RESET_WORD;
         `OFF_CH1_HOLD_12R:    rdata_next = {20'h00000, hold1};
         `OFF_CH1_HOLD_12L:    rdata_next = {16'h0000, hold1, 4'h0};
         `OFF_CH1_HOLD_8R:     rdata_next = {24'h000000, hold1[11:4]};
         `OFF_CH2_HOLD_12R:    rdata_next = {20'h00000, hold2};
         `OFF_CH2_HOLD_12L:    rdata_next = {16'h0000, hold2, 4'h0};
         `OFF_CH2_HOLD_8R:     rdata_next = {24'h000000, hold2[11:4]};
         `OFF_BOTH_HOLD_12R:   rdata_next = {4'h0, hold2, 4'h0, hold1};
         `OFF_BOTH_HOLD_12L:   rdata_next = {hold2, 4'h0, hold1, 4'h0};
         `OFF_BOTH_HOLD_8R:    rdata_next = {16'h0000, hold2[11:4], hold1[11:4]};
         `OFF_CH1_OUTPUT:      rdata_next = {20'h00000, out1};
         `OFF_CH2_OUTPUT:      rdata_next = {20'h00000, out2};
         `OFF_UNDERRUN_STATUS: rdata_next = status_reg;
         `OFF_IRQ_MASK:        rdata_next = mask_reg;
         default:              known_next = 1'b0;
      endcase
   end

   always @(posedge clk_in) begin
      if (reset_in) begin
         control_reg    <= `RESET_WORD;
         status_reg     <= `RESET_WORD;
         mask_reg       <= `RESET_WORD;
         prdata_out     <= `RESET_WORD;
         pready_out     <= 1'b0;
         pslverr_out    <= 1'b0;
         ch1_output_out <= `RESET_VALUE12;
         ch2_output_out <= `RESET_VALUE12;
         irq_out        <= 1'b0;
      end else begin
         pready_out  <= setup;
         pslverr_out <= setup & ~known_next;
         if (setup) begin
            prdata_out <= pwrite_in ? `RESET_WORD : rdata_next;
         end
         if (wr_go && paddr_in == `OFF_CONTROL) begin
            control_reg <= pwdata_in & `CONTROL_MASK;
         end
         if (wr_go && paddr_in == `OFF_IRQ_MASK) begin
            mask_reg <= pwdata_in & `STATUS_MASK;
         end
         // A fresh underrun wins over a clear in the same cycle
         if (wr_go && paddr_in == `OFF_UNDERRUN_STATUS) begin
            status_reg <= ((status_reg & ~pwdata_in) | set_bits) & `STATUS_MASK;
         end else begin
            status_reg <= (status_reg | set_bits) & `STATUS_MASK;
         end
         ch1_output_out <= out1;
         ch2_output_out <= out2;
         irq_out        <= |(status_reg & irq_gate);
      end
   end
endmodule

// ==== src/dac_data_regs.vh ====
// Register offsets, field positions and reset values of the dual-channel converter data block.
// Assumes a 32-bit APB slave with byte addresses; the includer supplies the module context.
//
// What this block does
// - Channel 1 soft trigger, cleared on transfer
// - Channel 2 soft trigger, cleared on transfer
// - Channel 1 twelve-bit right-aligned holding, bits 11:0
// - Channel 1 twelve-bit left-aligned holding, bits 15:4
// - Channel 1 eight-bit holding, bits 7:0
// - Channel 2 offers same three holding formats
// - Dual right-aligned: ch1 11:0, ch2 27:16
// - Dual left-aligned: ch1 15:4, ch2 31:20
// - Dual eight-bit: ch1 7:0, ch2 15:8
// - Sticky underrun flags bits 13/29, write-one clears
// - Channel 2 underrun interrupt needs enable bit 29
`ifndef DAC_DATA_REGS_VH
`define DAC_DATA_REGS_VH

`define OFF_CONTROL          8'h00
`define OFF_SOFT_TRIGGER     8'h04
`define OFF_CH1_HOLD_12R     8'h08
`define OFF_CH1_HOLD_12L     8'h0C
`define OFF_CH1_HOLD_8R      8'h10
`define OFF_CH2_HOLD_12R     8'h14
`define OFF_CH2_HOLD_12L     8'h18
`define OFF_CH2_HOLD_8R      8'h1C
`define OFF_BOTH_HOLD_12R    8'h20
`define OFF_BOTH_HOLD_12L    8'h24
`define OFF_BOTH_HOLD_8R     8'h28
`define OFF_CH1_OUTPUT       8'h2C
`define OFF_CH2_OUTPUT       8'h30
`define OFF_UNDERRUN_STATUS  8'h34
`define OFF_IRQ_MASK         8'h38

`define BIT_CH1_SOFT_TRIGGER 0
`define BIT_CH2_SOFT_TRIGGER 1
`define BIT_CH1_TRIG_ENABLE  2
`define BIT_CH2_TRIG_ENABLE  18
`define BIT_CH1_UNDERRUN     13
`define BIT_CH2_UNDERRUN     29
`define BIT_CH2_UNDERRUN_IEN 29

`define LSB_R12_CH2          16
`define LSB_L12_CH1          4
`define LSB_L12_CH2          20
`define LSB_R8_CH2           8

`define RESET_WORD           32'h00000000
`define RESET_VALUE12        12'h000
`define STATUS_MASK          32'h20002000
`define CONTROL_MASK         32'h20040004

`endif

// ==== src/dac_channel.v ====
// One converter channel: holding value, trigger bit and output register.
// Assumes the register block decodes writes and hands over the twelve-bit value.
`timescale 1ns/1ps
module dac_channel #(
   parameter WIDTH = 12
) (
   input  wire             clk_in,
   input  wire             reset_in,
   input  wire             hold_write_in,
   input  wire [WIDTH-1:0] hold_data_in,
   input  wire             trig_enable_in,
   input  wire             soft_set_in,
   input  wire             soft_clear_in,
   input  wire             hw_trigger_in,
   output reg  [WIDTH-1:0] hold_value_out,
   output reg  [WIDTH-1:0] output_value_out,
   output reg              soft_trigger_out
);
   reg             pending_reg;
   wire            fire;

   // Untriggered mode loads one clock after the holding write lands
   assign fire = trig_enable_in ? (soft_trigger_out | hw_trigger_in) : pending_reg;

   always @(posedge clk_in) begin
      if (reset_in) begin
         hold_value_out   <= {WIDTH{1'b0}};
         output_value_out <= {WIDTH{1'b0}};
         soft_trigger_out <= 1'b0;
         pending_reg      <= 1'b0;
      end else begin
         if (hold_write_in) begin
            hold_value_out <= hold_data_in;
         end
         pending_reg <= hold_write_in & ~trig_enable_in;
         if (fire) begin
            output_value_out <= hold_value_out;
         end
         // A new set from software wins over the hardware clear
         if (soft_set_in) begin
            soft_trigger_out <= 1'b1;
         end else if (fire | soft_clear_in) begin
            soft_trigger_out <= 1'b0;
         end
      end
   end
endmodule

// ==== sim/dac_regs_monitor.sv ====
// Port checker of the converter data registers.
// Assumes the zero-wait APB timing of the block; bound to every instance.
`timescale 1ns/1ps
`include "dac_data_regs.vh"
module dac_regs_monitor #(
   parameter WIDTH = 12
) (
   input wire             clk_in,
   input wire             reset_in,
   input wire             psel_in,
   input wire             penable_in,
   input wire             pwrite_in,
   input wire [7:0]       paddr_in,
   input wire [31:0]      pwdata_in,
   input wire             ch1_hw_trigger_in,
   input wire             ch2_hw_trigger_in,
   input wire             ch1_underrun_in,
   input wire             ch2_underrun_in,
   input wire [31:0]      prdata_out,
   input wire             pready_out,
   input wire             pslverr_out,
   input wire [WIDTH-1:0] ch1_output_out,
   input wire [WIDTH-1:0] ch2_output_out,
   input wire             irq_out
);
   reg  [31:0] ctl_reg;
   reg  [31:0] msk_reg;
   wire        wr = psel_in && penable_in && pready_out && pwrite_in;
   // Masked only when neither path can reach the line
   wire        quiet = !msk_reg[13] && !(msk_reg[29] && ctl_reg[29]);
   always @(posedge clk_in) begin
      if (reset_in) begin
         ctl_reg <= 32'h00000000;
         msk_reg <= 32'h00000000;
      end else if (wr && paddr_in == `OFF_CONTROL) begin
         ctl_reg <= pwdata_in;
      end else if (wr && paddr_in == `OFF_IRQ_MASK) begin
         msk_reg <= pwdata_in;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_setup; psel_in && !penable_in; endsequence
   sequence s_rd(ad); psel_in && penable_in && pready_out && !pwrite_in && paddr_in == ad; endsequence
   a_ready_setup: assert property (s_setup |=> pready_out) else $error("ready missing");
   a_ready_single: assert property (pready_out |=> !pready_out) else $error("ready too long");
   a_err_unmapped: assert property (pready_out && psel_in && (paddr_in > `OFF_IRQ_MASK
      || paddr_in[1:0] != 2'h0) |-> pslverr_out) else $error("no error on bad address");
   a_trig_reads_zero: assert property (
      s_rd(`OFF_SOFT_TRIGGER) |-> prdata_out == 32'h00000000) else $error("trigger read");
   a_out_upper_zero: assert property (
      s_rd(`OFF_CH1_OUTPUT) |-> prdata_out[31:12] == 20'h00000) else $error("output read");
   a_ch1_direct: assert property (
      wr && paddr_in == `OFF_CH1_HOLD_12R && !ctl_reg[2] |-> ##3
      ch1_output_out == $past(pwdata_in[11:0], 3)) else $error("ch1 output late");
   a_ch2_direct: assert property (
      wr && paddr_in == `OFF_BOTH_HOLD_12L && !ctl_reg[18] |-> ##3
      ch2_output_out == $past(pwdata_in[31:20], 3)) else $error("ch2 output late");
   a_irq_set: assert property (
      ch1_underrun_in && msk_reg[13] |-> ##2 irq_out) else $error("irq missing");
   a_irq_gate: assert property ($past(quiet) |-> !irq_out) else $error("irq unmasked");
   a_irq_cause: assert property ($rose(irq_out) |->
      $past(ch1_underrun_in || ch2_underrun_in || wr, 2)) else $error("irq without cause");
endmodule
bind dac_data_registers dac_regs_monitor #(.WIDTH(WIDTH)) mon (.clk_in, .reset_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .ch1_hw_trigger_in, .ch2_hw_trigger_in,
   .ch1_underrun_in, .ch2_underrun_in, .prdata_out, .pready_out, .pslverr_out,
   .ch1_output_out, .ch2_output_out, .irq_out);

// ==== sim/dac_data_registers_tb.sv ====
// Self-checking bench of the converter data registers.
// Assumes only the design files; the bench drives every port itself.
`timescale 1ns/1ps
`include "dac_data_regs.vh"
module dac_data_registers_tb;
   logic        clk_in = 1'h0, reset_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
   logic        pwrite_in = 1'h0, ch1_hw_trigger_in = 1'h0, ch2_hw_trigger_in = 1'h0;
   logic        ch1_underrun_in = 1'h0, ch2_underrun_in = 1'h0, e;
   logic [7:0]  paddr_in = 8'h00, a;
   logic [31:0] pwdata_in = 32'h00000000, r, d;
   logic [11:0] m1 = 12'h000, m2 = 12'h000;
   wire  [31:0] prdata_out;
   wire         pready_out, pslverr_out, irq_out;
   wire  [11:0] ch1_output_out, ch2_output_out;
   int          n_mismatch = 0, n_tests = 0, cyc = 0;
   dac_data_registers uut (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .ch1_hw_trigger_in, .ch2_hw_trigger_in, .ch1_underrun_in, .ch2_underrun_in,
      .prdata_out, .pready_out, .pslverr_out, .ch1_output_out, .ch2_output_out, .irq_out);
   always #20 clk_in = ~clk_in;
   task automatic stop_test;
      $display("Mismatches %0d in %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         stop_test;
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Starts on an edge of its own, so back-to-back calls never drive twice in one step
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int k;
      @(posedge clk_in);
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= ad;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'h1;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (pready_out !== 1'h1 && k < 16);
      r = prdata_out;
      e = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
      if (k >= 16) n_mismatch++;
   endtask
   task automatic pulse(input logic [3:0] v);
      @(posedge clk_in);
      {ch1_hw_trigger_in, ch2_hw_trigger_in, ch1_underrun_in, ch2_underrun_in} <= v;
      @(posedge clk_in);
      {ch1_hw_trigger_in, ch2_hw_trigger_in, ch1_underrun_in, ch2_underrun_in} <= 4'h0;
      repeat (2) @(posedge clk_in);
   endtask
   function automatic logic [11:0] exp_val(input logic [7:0] ad, input logic [31:0] v, bit c2);
      case (ad)
         `OFF_CH1_HOLD_12R, `OFF_CH2_HOLD_12R: return v[11:0];
         `OFF_CH1_HOLD_12L, `OFF_CH2_HOLD_12L: return v[15:4];
         `OFF_CH1_HOLD_8R, `OFF_CH2_HOLD_8R: return {v[7:0], 4'h0};
         `OFF_BOTH_HOLD_12R: return c2 ? v[27:16] : v[11:0];
         `OFF_BOTH_HOLD_12L: return c2 ? v[31:20] : v[15:4];
         default: return c2 ? {v[15:8], 4'h0} : {v[7:0], 4'h0};
      endcase
   endfunction
   // Read-back view of the shared twelve-bit values in each holding format
   function automatic logic [31:0] rd_exp(input logic [7:0] ad);
      case (ad)
         `OFF_CH1_HOLD_12R: return {20'h00000, m1};
         `OFF_CH1_HOLD_12L: return {16'h0000, m1, 4'h0};
         `OFF_CH1_HOLD_8R: return {24'h000000, m1[11:4]};
         `OFF_CH2_HOLD_12R: return {20'h00000, m2};
         `OFF_CH2_HOLD_12L: return {16'h0000, m2, 4'h0};
         `OFF_CH2_HOLD_8R: return {24'h000000, m2[11:4]};
         `OFF_BOTH_HOLD_12R: return {4'h0, m2, 4'h0, m1};
         `OFF_BOTH_HOLD_12L: return {m2, 4'h0, m1, 4'h0};
         default: return {16'h0000, m2[11:4], m1[11:4]};
      endcase
   endfunction
   function automatic bit hits(input logic [7:0] ad, input bit c2);
      return c2 ? ad >= 8'h14 : (ad < 8'h14 || ad >= 8'h20);
   endfunction
   task automatic outs(input logic [11:0] x1, input logic [11:0] x2);
      repeat (3) @(posedge clk_in);
      check("ch1 out", ch1_output_out, x1);
      check("ch2 out", ch2_output_out, x2);
   endtask
   initial begin
      void'($urandom(32'h04CB));
      repeat (4) @(posedge clk_in);
      reset_in <= 1'h0;
      for (int i = 0; i <= 14; i++) begin
         apb(1'h0, 8'(i * 4), 32'h00000000);
         check("reset value", r, `RESET_WORD);
      end
      apb(1'h0, 8'h3C, 32'h00000000);
      check("unmapped error", {31'h0, e}, 32'h1);
      repeat (40) begin
         a = 8'h08 + 8'($urandom_range(8)) * 8'h04;
         d = $urandom;
         apb(1'h1, a, d);
         if (hits(a, 1'b0)) m1 = exp_val(a, d, 1'b0);
         if (hits(a, 1'b1)) m2 = exp_val(a, d, 1'b1);
         outs(m1, m2);
         apb(1'h0, a, 32'h00000000);
         check("holding readback", r, rd_exp(a));
      end
      apb(1'h1, `OFF_CH2_OUTPUT, $urandom);
      apb(1'h0, `OFF_CH2_OUTPUT, 32'h00000000);
      check("ch2 output reg", r, {20'h00000, m2});
      // Trigger mode: holding writes alone must leave the outputs alone
      apb(1'h1, `OFF_CONTROL, 32'h00040004);
      apb(1'h1, `OFF_CH1_HOLD_12R, 32'h00000ABC);
      apb(1'h1, `OFF_CH2_HOLD_8R, 32'h00000012);
      outs(m1, m2);
      apb(1'h1, `OFF_SOFT_TRIGGER, 32'h00000003);
      outs(12'hABC, 12'h120);
      apb(1'h1, `OFF_BOTH_HOLD_12R, 32'h04560789);
      outs(12'hABC, 12'h120);
      pulse(4'hC);
      outs(12'h789, 12'h456);
      apb(1'h1, `OFF_IRQ_MASK, `STATUS_MASK);
      pulse(4'h2);
      check("irq ch1", irq_out, 32'h1);
      apb(1'h0, `OFF_UNDERRUN_STATUS, 32'h00000000);
      check("status ch1", r, 32'h00002000);
      apb(1'h1, `OFF_UNDERRUN_STATUS, 32'h00002000);
      pulse(4'h1);
      check("irq gated", irq_out, 32'h0);
      apb(1'h0, `OFF_UNDERRUN_STATUS, 32'h00000000);
      check("status ch2", r, 32'h20000000);
      apb(1'h1, `OFF_CONTROL, `CONTROL_MASK);
      repeat (3) @(posedge clk_in);
      check("irq ch2", irq_out, 32'h1);
      apb(1'h1, `OFF_UNDERRUN_STATUS, 32'h20000000);
      repeat (3) @(posedge clk_in);
      check("irq cleared", irq_out, 32'h0);
      stop_test;
   end
endmodule
